// ---- include/status_port_consts.vh ----
// How it works
// RULE1 - each port pin has a direction bit, 0 input, 1 output, cleared to input at reset
// RULE2 - each port pin has a sense bit, 0 level, 1 falling edge, reset to level
// RULE3 - port pins are sampled every instruction-cycle clock rising edge into the input latch
// RULE4 - outside source holds a new input level at least one full instruction cycle
// RULE5 - edge-sensing pin latch bit sets on falling edge and holds until tested
// RULE6 - port data sits in the low 8 bits; upper bits read undefined (here zero)
// RULE7 - direction and sense bits 15:8 are reserved; writes ignored, reads undefined (zero)
// RULE8 - condition evaluator offers true and inverted tests for each of eight port bits
// RULE9 - mode register resets to 004c; bit 15 enables interrupts, default off
// RULE10 - mode bit 14 set by trigger or software, cleared by hardware on acknowledge
// RULE11 - mode bits 13,12 pick bit reverse; bits 11 to 8 pick modulo per pointer
// RULE12 - mode bit 7 picks rounding: 0 convergent at reset, 1 two's complement
// RULE13 - with clipping on, clip at 32-bit overflow if wide bit 0, 40-bit if 1
// RULE14 - fractional mode shifts signed product left one bit; integer mode does not shift
// RULE15 - two mode bits mark right and left operands signed (reset) or unsigned
// RULE16 - two wide-mode bits join high and low input registers into 32-bit operands
// RULE17 - flag register updates after each ALU operation and resets to zero
// RULE18 - flag bits 15:14 hold loop level pointer 00 to 11 selecting loop bank
// RULE19 - record carry from bits 39 and 31 (31 not on double multiply) and result bit 16
// RULE20 - normalized when bits 39:31 equal each other and differ from bit 30; ext on 32-bit overflow
// RULE21 - sticky normalized and sticky overflow flags set on event, cleared when tested
// RULE22 - less-than is sign xor overflow, less-or-equal adds zero; complements, always, never
// RULE23 - a test instruction may pick a port bit as a branch condition
// RULE24 - output pins driven from output latch; input pins left undriven
`ifndef STATUS_PORT_CONSTS_VH
`define STATUS_PORT_CONSTS_VH
`define ADDR_PIN_DIR 4'h0
`define ADDR_PIN_SENSE 4'h1
`define ADDR_MODE 4'h2
`define ADDR_FLAGS 4'h3
`define ADDR_PIN_IN 4'h4
`define ADDR_PIN_OUT 4'h5
`define MODE_RESET 16'h004c
`define MODE_EI 15
`define MODE_IRQ 14
`define FLAG_RSVD 13
`define FLAG_TST 12
`define FLAG_C31 11
`define FLAG_NQ 10
`define FLAG_CS 9
`define FLAG_PAR 8
`define FLAG_MN 7
`define FLAG_N 6
`define FLAG_EXT 5
`define FLAG_STICKY_OVERFLOW_FLAG 4
`define FLAG_OVF 3
`define FLAG_Z 2
`define FLAG_C 1
`define FLAG_S 0
`define COND_ALWAYS 5'h00
`define COND_Z 5'h01
`define COND_LT 5'h02
`define COND_LTE 5'h03
`define COND_C 5'h04
`define COND_S 5'h05
`define COND_EXT 5'h06
`define COND_OVF 5'h07
`define COND_STICKY_OVERFLOW_FLAG 5'h08
`define COND_N 5'h09
`define COND_MN 5'h0a
`define COND_PAR 5'h0b
`define COND_C31 5'h0c
`define COND_TST 5'h0d
`define COND_PORT 5'h10
`endif

// ---- verilog/status_condition_port.v ----
// Chosen here: the address map and strobed register access.
`include "status_port_consts.vh"
module status_condition_port #(
  parameter PORT_W = 8
) (
  input wire clk, // core clock, one edge per instruction cycle
  input wire rst, // synchronous reset, active high
  input wire [3:0] reg_addr, // register address
  input wire [15:0] reg_wdata, // register write data
  input wire reg_wr, // write strobe
  input wire reg_rd, // read strobe
  output reg [15:0] reg_rdata, // read data, cycle after strobe
  input wire [PORT_W-1:0] port_in, // port pin input level
  output reg [PORT_W-1:0] port_out, // port pin drive value
  output reg [PORT_W-1:0] port_oe, // port pin output enable
  input wire irq_trigger, // interrupt trigger event pulse
  input wire irq_ack, // interrupt acknowledge pulse
  input wire alu_valid, // alu result written to accumulator
  input wire [39:0] alu_result, // last alu result
  input wire alu_carry39, // carry out of bit 39
  input wire alu_carry31, // carry out of bit 31
  input wire alu_double_precision_multiply, // result from double precision multiply
  input wire alu_ovf40, // 40-bit overflow of result
  input wire alu_tst, // test bit from bit test or shift
  input wire alu_nq_load, // division step loads next quotient
  input wire alu_nq, // next quotient complement
  input wire alu_cs_load, // compare sign load
  input wire alu_cs, // compared sign value
  input wire loop_inc, // loop level pointer increment
  input wire loop_dec, // loop level pointer decrement
  input wire cond_test, // conditional instruction tests cond_sel
  input wire [4:0] cond_sel, // condition code select
  input wire cond_inv, // select inverted condition
  output reg cond_true, // selected condition result
  output wire irq_enable, // interrupts enabled
  output wire irq_pending, // interrupt request flag
  output wire bitrev_x_ptr_1, // bit reverse on second x pointer
  output wire bitrev_x_ptr_0, // bit reverse on first x pointer
  output wire modulo_y_ptr_1, // modulo update on second y pointer
  output wire modulo_y_ptr_0, // modulo update on first y pointer
  output wire modulo_x_ptr_1, // modulo update on second x pointer
  output wire modulo_x_ptr_0, // modulo update on first x pointer
  output wire rounding_select, // 0 convergent, 1 twos complement
  output wire clip_at_40, // clip threshold is 40-bit overflow
  output wire clip_at_32, // clip threshold is 32-bit overflow
  output wire product_shift, // shift signed product left by one
  output wire right_operand_signed, // right operand signed
  output wire left_operand_signed, // left operand signed
  output wire right_wide_mode, // right pair as 32-bit operand
  output wire left_wide_mode, // left pair as 32-bit operand
  output wire [1:0] loop_level_pointer, // current loop bank
  output wire [15:0] flags_out // condition flag register value
);

  reg [PORT_W-1:0] pin_direction_reg;
  reg [PORT_W-1:0] pin_sense_reg;
  reg [PORT_W-1:0] out_latch_r;
  reg [PORT_W-1:0] sync1_r;
  reg [PORT_W-1:0] sync2_r;
  reg [PORT_W-1:0] prev_r;
  reg [PORT_W-1:0] pin_input_latch;
  reg [15:0] mode_control_reg;
  reg [15:0] condition_flags_reg;
  reg [15:0] flags_nxt;
  reg [15:0] mode_nxt;
  reg [PORT_W-1:0] port_test;
  reg cond_raw;
  wire lt;
  wire norm;
  wire ovf32;
  wire flags_wr;
  wire wide_on;

  // mode field decode toward address units and datapath
  assign irq_enable = mode_control_reg[`MODE_EI]; // RULE9
  assign irq_pending = mode_control_reg[`MODE_IRQ];
  assign bitrev_x_ptr_1 = mode_control_reg[13]; // RULE11
  assign bitrev_x_ptr_0 = mode_control_reg[12];
  assign modulo_y_ptr_1 = mode_control_reg[11];
  assign modulo_y_ptr_0 = mode_control_reg[10];
  assign modulo_x_ptr_1 = mode_control_reg[9];
  assign modulo_x_ptr_0 = mode_control_reg[8];
  assign rounding_select = mode_control_reg[7]; // RULE12
  assign wide_on = mode_control_reg[5];
  assign clip_at_40 = wide_on & mode_control_reg[6]; // RULE13
  assign clip_at_32 = wide_on & ~mode_control_reg[6]; // RULE13
  assign product_shift = ~mode_control_reg[4] & mode_control_reg[3] & mode_control_reg[2]; // RULE14
  assign right_operand_signed = mode_control_reg[3]; // RULE15
  assign left_operand_signed = mode_control_reg[2]; // RULE15
  assign right_wide_mode = mode_control_reg[1]; // RULE16
  assign left_wide_mode = mode_control_reg[0]; // RULE16
  assign loop_level_pointer = condition_flags_reg[15:14]; // RULE18
  assign flags_out = condition_flags_reg;

  // result classification
  assign norm = (&alu_result[39:31] | ~|alu_result[39:31]) & (alu_result[31] ^ alu_result[30]); // RULE20
  assign ovf32 = ~(&alu_result[39:31] | ~|alu_result[39:31]); // RULE20
  assign lt = condition_flags_reg[`FLAG_S] ^ condition_flags_reg[`FLAG_OVF]; // RULE22
  assign flags_wr = reg_wr && reg_addr == `ADDR_FLAGS;

  // condition evaluator
  always @* begin
    port_test = {PORT_W{1'b0}};
    case (cond_sel)
      `COND_ALWAYS: cond_raw = 1'b1; // RULE22
      `COND_Z: cond_raw = condition_flags_reg[`FLAG_Z];
      `COND_LT: cond_raw = lt; // RULE22
      `COND_LTE: cond_raw = lt | condition_flags_reg[`FLAG_Z]; // RULE22
      `COND_C: cond_raw = condition_flags_reg[`FLAG_C];
      `COND_S: cond_raw = condition_flags_reg[`FLAG_S];
      `COND_EXT: cond_raw = condition_flags_reg[`FLAG_EXT];
      `COND_OVF: cond_raw = condition_flags_reg[`FLAG_OVF];
      `COND_STICKY_OVERFLOW_FLAG: cond_raw = condition_flags_reg[`FLAG_STICKY_OVERFLOW_FLAG];
      `COND_N: cond_raw = condition_flags_reg[`FLAG_N];
      `COND_MN: cond_raw = condition_flags_reg[`FLAG_MN];
      `COND_PAR: cond_raw = condition_flags_reg[`FLAG_PAR];
      `COND_C31: cond_raw = condition_flags_reg[`FLAG_C31];
      `COND_TST: cond_raw = condition_flags_reg[`FLAG_TST];
      default: begin
        if (cond_sel[4] && cond_sel[3:0] < PORT_W) begin
          cond_raw = pin_input_latch[cond_sel[2:0]]; // RULE8 RULE23
          port_test[cond_sel[2:0]] = cond_test; // RULE5
        end else begin
          cond_raw = 1'b0;
        end
      end
    endcase
    cond_true = cond_raw ^ cond_inv; // RULE8 RULE22
  end

  // port: direction, sense, output latch, drive
  always @(posedge clk) begin
    if (rst) begin
      pin_direction_reg <= {PORT_W{1'b0}}; // RULE1
      pin_sense_reg <= {PORT_W{1'b0}}; // RULE2
      out_latch_r <= {PORT_W{1'b0}};
      port_out <= {PORT_W{1'b0}};
      port_oe <= {PORT_W{1'b0}};
    end else begin
      if (reg_wr && reg_addr == `ADDR_PIN_DIR) pin_direction_reg <= reg_wdata[PORT_W-1:0]; // RULE7
      if (reg_wr && reg_addr == `ADDR_PIN_SENSE) pin_sense_reg <= reg_wdata[PORT_W-1:0]; // RULE7
      if (reg_wr && reg_addr == `ADDR_PIN_OUT) out_latch_r <= reg_wdata[PORT_W-1:0]; // RULE6
      port_out <= out_latch_r & pin_direction_reg; // RULE24
      port_oe <= pin_direction_reg; // RULE24
    end
  end

  // input sampling, falling-edge capture held until tested
  genvar i;
  generate
    for (i = 0; i < PORT_W; i = i + 1) begin : g_pin
      always @(posedge clk) begin
        if (rst) begin
          sync1_r[i] <= 1'b0;
          sync2_r[i] <= 1'b0;
          prev_r[i] <= 1'b0;
          pin_input_latch[i] <= 1'b0;
        end else begin
          sync1_r[i] <= port_in[i]; // RULE3 RULE4
          sync2_r[i] <= sync1_r[i];
          prev_r[i] <= sync2_r[i];
          if (!pin_sense_reg[i]) begin
            pin_input_latch[i] <= sync2_r[i]; // RULE3
          end else if (prev_r[i] && !sync2_r[i]) begin
            pin_input_latch[i] <= 1'b1; // RULE5
          end else if (port_test[i]) begin
            pin_input_latch[i] <= 1'b0; // RULE5
          end
        end
      end
    end
  endgenerate

  // mode register next value
  always @* begin
    mode_nxt = mode_control_reg;
    if (reg_wr && reg_addr == `ADDR_MODE) mode_nxt = reg_wdata;
    if (irq_ack) mode_nxt[`MODE_IRQ] = 1'b0; // RULE10
    if (irq_trigger) mode_nxt[`MODE_IRQ] = 1'b1; // RULE10
  end

  // flag register next value
  always @* begin
    flags_nxt = condition_flags_reg;
    if (flags_wr) flags_nxt = reg_wdata;
    if (loop_inc && !loop_dec) flags_nxt[15:14] = condition_flags_reg[15:14] + 2'h1; // RULE18
    if (loop_dec && !loop_inc) flags_nxt[15:14] = condition_flags_reg[15:14] - 2'h1; // RULE18
    if (cond_test && cond_sel == `COND_MN) flags_nxt[`FLAG_MN] = 1'b0; // RULE21
    if (cond_test && cond_sel == `COND_STICKY_OVERFLOW_FLAG) flags_nxt[`FLAG_STICKY_OVERFLOW_FLAG] = 1'b0; // RULE21
    if (alu_valid) begin
      flags_nxt[`FLAG_C] = alu_carry39; // RULE17 RULE19
      if (!alu_double_precision_multiply) flags_nxt[`FLAG_C31] = alu_carry31; // RULE19
      flags_nxt[`FLAG_PAR] = alu_result[16]; // RULE19
      flags_nxt[`FLAG_S] = alu_result[39];
      flags_nxt[`FLAG_Z] = ~|alu_result;
      flags_nxt[`FLAG_N] = norm; // RULE20
      flags_nxt[`FLAG_EXT] = ovf32; // RULE20
      flags_nxt[`FLAG_OVF] = alu_ovf40;
      flags_nxt[`FLAG_TST] = alu_tst;
      if (norm) flags_nxt[`FLAG_MN] = 1'b1; // RULE21
      if (alu_ovf40) flags_nxt[`FLAG_STICKY_OVERFLOW_FLAG] = 1'b1; // RULE21
    end
    if (alu_nq_load) flags_nxt[`FLAG_NQ] = alu_nq;
    if (alu_cs_load) flags_nxt[`FLAG_CS] = alu_cs;
    flags_nxt[`FLAG_RSVD] = 1'b0;
  end

  // mode and flag registers
  always @(posedge clk) begin
    if (rst) begin
      mode_control_reg <= `MODE_RESET; // RULE9
      condition_flags_reg <= 16'h0000; // RULE17
    end else begin
      mode_control_reg <= mode_nxt;
      condition_flags_reg <= flags_nxt;
    end
  end

  // read data, one cycle after read strobe, zero otherwise
  always @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      if (reg_addr == `ADDR_PIN_DIR) reg_rdata <= {8'h00, pin_direction_reg}; // RULE7
      else if (reg_addr == `ADDR_PIN_SENSE) reg_rdata <= {8'h00, pin_sense_reg}; // RULE7
      else if (reg_addr == `ADDR_MODE) reg_rdata <= mode_control_reg;
      else if (reg_addr == `ADDR_FLAGS) reg_rdata <= condition_flags_reg;
      else if (reg_addr == `ADDR_PIN_IN) reg_rdata <= {8'h00, pin_input_latch}; // RULE6
      else if (reg_addr == `ADDR_PIN_OUT) reg_rdata <= {8'h00, out_latch_r}; // RULE6
      else reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

endmodule

// ---- test/status_condition_port_properties.sv ----
`include "status_port_consts.vh"
module scp_checker #(parameter PORT_W = 8) (
  input wire clk, rst, reg_wr, irq_trigger, irq_ack, alu_valid, alu_carry39, alu_double_precision_multiply, alu_ovf40, // strobes, events
  input wire [3:0] reg_addr, // register address
  input wire [15:0] reg_wdata, flags_out, // write data, flag register
  input wire [39:0] alu_result, // last alu result
  input wire [PORT_W-1:0] port_out, port_oe, // pin drive and enable
  input wire loop_inc, loop_dec, cond_test, cond_inv, cond_true, irq_pending, irq_enable, // control and status
  input wire product_shift, right_operand_signed, left_operand_signed, rounding_select, clip_at_40, // mode decode
  input wire [4:0] cond_sel, // condition select
  input wire [1:0] loop_level_pointer // loop bank
);
  timeunit 1ns;
  timeprecision 100ps;
  // result classification and software flag writes, which lose to hardware updates
  wire norm = alu_result[39:30] == 10'h001 || alu_result[39:30] == 10'h3fe;
  wire overflow_32_flag = !(alu_result[39:31] == 9'h000 || alu_result[39:31] == 9'h1ff);
  wire fw = reg_wr && reg_addr == `ADDR_FLAGS;
  wire res16 = alu_result[16];
  wire res39 = alu_result[39];
  wire [PORT_W-1:0] dir_wdata = reg_wdata[PORT_W-1:0];
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_RST: assert property (disable iff (1'b0) rst |=> flags_out == 16'h0 && port_oe == '0 && !irq_enable
    && product_shift && right_operand_signed && left_operand_signed && !rounding_select && !clip_at_40)
    else $error("reset state wrong");
  AST_DIR: assert property (reg_wr && reg_addr == `ADDR_PIN_DIR ##1 !(reg_wr && reg_addr == `ADDR_PIN_DIR)
    |=> port_oe == $past(dir_wdata, 2)) else $error("direction not applied");
  AST_DRIVE: assert property ((port_out & ~port_oe) == '0) else $error("input pin driven");
  AST_IRQ_SET: assert property (irq_trigger |=> irq_pending) else $error("trigger lost");
  AST_IRQ_ACK: assert property (irq_ack && !irq_trigger |=> !irq_pending) else $error("ack ignored");
  AST_FLAGS: assert property (alu_valid && !fw |=> flags_out[`FLAG_PAR] == $past(res16)
    && flags_out[`FLAG_S] == $past(res39) && flags_out[`FLAG_C] == $past(alu_carry39)) else $error("flags wrong");
  AST_C31: assert property (alu_valid && alu_double_precision_multiply && !fw |=> $stable(flags_out[`FLAG_C31]))
    else $error("c31 loaded on double multiply");
  AST_NORM: assert property (alu_valid && !fw |=> flags_out[`FLAG_N] == $past(norm)
    && flags_out[`FLAG_EXT] == $past(overflow_32_flag)) else $error("normalized or extension wrong");
  AST_STICKY: assert property (alu_valid && !fw |=> (!$past(norm) || flags_out[`FLAG_MN])
    && (!$past(alu_ovf40) || flags_out[`FLAG_STICKY_OVERFLOW_FLAG])) else $error("sticky flag not set");
  AST_CLR: assert property (cond_test && cond_sel == `COND_MN && !alu_valid && !fw |=> !flags_out[`FLAG_MN])
    else $error("sticky flag not cleared");
  AST_LTE: assert property (cond_inv && cond_sel == `COND_LTE |-> cond_true ==
    !(flags_out[`FLAG_S] ^ flags_out[`FLAG_OVF] | flags_out[`FLAG_Z])) else $error("greater-than wrong");
  AST_LOOP: assert property (loop_inc && !loop_dec && !fw && loop_level_pointer != 2'h3
    |=> loop_level_pointer == $past(loop_level_pointer) + 2'h1) else $error("loop pointer not stepped");
endmodule
bind status_condition_port scp_checker #(.PORT_W(PORT_W)) scp_checker_i (.clk, .rst, .reg_wr, .irq_trigger, .irq_ack,
  .alu_valid, .alu_carry39, .alu_double_precision_multiply, .alu_ovf40, .reg_addr, .reg_wdata, .flags_out, .alu_result, .port_out,
  .port_oe, .loop_inc, .loop_dec, .cond_test, .cond_inv, .cond_true, .irq_pending, .irq_enable, .product_shift,
  .right_operand_signed, .left_operand_signed, .rounding_select, .clip_at_40, .cond_sel, .loop_level_pointer);

// ---- test/pin_source.sv ----
module pin_source (
  input wire clk, // core clock
  input wire [7:0] want, // level the source wants on its pins
  input wire [7:0] port_out, // device drive value
  input wire [7:0] port_oe, // device drive enable
  output wire [7:0] pin_level // resolved pin level
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] drv_r = 8'hff;
  // a new level is launched on an edge and held at least one whole cycle
  always @(posedge clk) drv_r <= want;
  // output pins follow the device, input pins follow the source
  assign pin_level = (port_oe & port_out) | (~port_oe & drv_r);
endmodule

// ---- test/testbench.sv ----
`include "status_port_consts.vh"
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, irq_trigger = 0, irq_ack = 0, alu_valid = 0, alu_carry39 = 0;
  logic alu_carry31 = 0, alu_double_precision_multiply = 0, alu_ovf40 = 0, alu_tst = 0, loop_inc = 0, loop_dec = 0, cond_test = 0;
  logic cond_inv = 0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0, d, w;
  logic [39:0] alu_result = 40'h0;
  logic [4:0] cond_sel = 5'h0;
  logic [7:0] want = 8'hff;
  wire [15:0] reg_rdata, flags_out;
  wire [7:0] port_out, port_oe, pin_level;
  wire [1:0] loop_level_pointer;
  wire cond_true, irq_enable, irq_pending, bitrev_x_ptr_1, bitrev_x_ptr_0, modulo_y_ptr_1, modulo_y_ptr_0;
  wire modulo_x_ptr_1, modulo_x_ptr_0, rounding_select, clip_at_40, clip_at_32, product_shift;
  wire right_operand_signed, left_operand_signed, right_wide_mode, left_wide_mode;
  wire [15:0] mdec = {irq_enable, irq_pending, bitrev_x_ptr_1, bitrev_x_ptr_0, modulo_y_ptr_1, modulo_y_ptr_0,
    modulo_x_ptr_1, modulo_x_ptr_0, rounding_select, clip_at_40, clip_at_32, product_shift, right_operand_signed,
    left_operand_signed, right_wide_mode, left_wide_mode};
  int fails = 0, checked = 0;
  localparam logic [3:0] POS [16] = '{0, 2, 0, 0, 1, 0, 5, 3, 4, 6, 7, 8, 11, 12, 0, 0};
  status_condition_port #(.PORT_W(8)) status_condition_port_i (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .port_in(pin_level), .port_out, .port_oe, .irq_trigger, .irq_ack, .alu_valid, .alu_result,
    .alu_carry39, .alu_carry31, .alu_double_precision_multiply, .alu_ovf40, .alu_tst, .alu_nq_load(1'b0), .alu_nq(1'b0),
    .alu_cs_load(1'b0), .alu_cs(1'b0), .loop_inc, .loop_dec, .cond_test, .cond_sel, .cond_inv, .cond_true,
    .irq_enable, .irq_pending, .bitrev_x_ptr_1, .bitrev_x_ptr_0, .modulo_y_ptr_1, .modulo_y_ptr_0, .modulo_x_ptr_1,
    .modulo_x_ptr_0, .rounding_select, .clip_at_40, .clip_at_32, .product_shift, .right_operand_signed,
    .left_operand_signed, .right_wide_mode, .left_wide_mode, .loop_level_pointer, .flags_out);
  pin_source pin_source_i (.clk, .want, .port_out, .port_oe, .pin_level);
  always #12.5 clk = ~clk;
  // comparison, bus cycles and pulses
  task chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk) {reg_addr, reg_wdata, reg_wr} <= {a, v, 1'b1};
    @(posedge clk) reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge clk) {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge clk) reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task ctest(input logic [4:0] s);
    @(posedge clk) {cond_sel, cond_test} <= {s, 1'b1};
    @(posedge clk) cond_test <= 1'b0;
  endtask
  task alu(input logic [39:0] r, input logic o);
    @(posedge clk) {alu_valid, alu_result, alu_ovf40} <= {1'b1, r, o};
    {alu_carry39, alu_carry31, alu_double_precision_multiply, alu_tst} <= 4'($urandom);
    @(posedge clk) alu_valid <= 1'b0;
  endtask
  task give_verdict;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // expected mode decode and condition results
  function logic [15:0] mexp(input logic [15:0] m);
    return {m[15:7], m[5] & m[6], m[5] & ~m[6], ~m[4] & m[3] & m[2], m[3:0]};
  endfunction
  function logic ce(input logic [15:0] f, input logic [4:0] s, input logic i);
    logic lt;
    lt = f[0] ^ f[3];
    case (s)
      5'h00: ce = 1'b1;
      5'h02: ce = lt;
      5'h03: ce = lt | f[2];
      default: ce = s < 5'h0e && f[POS[s[3:0]]];
    endcase
    return ce ^ i;
  endfunction
  initial begin
    void'($urandom(32'h896e));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(`ADDR_MODE); chk(d, `MODE_RESET);
    chk(mdec, mexp(`MODE_RESET));
    rd(`ADDR_FLAGS); chk(d, 16'h0);
    rd(`ADDR_PIN_DIR); chk(d, 16'h0);
    rd(`ADDR_PIN_SENSE); chk(d, 16'h0);
    rd(4'hf); chk(d, 16'h0);
    $display("reset test done");
    for (int k = 0; k < 4; k++) begin
      w = 16'($urandom);
      wr(`ADDR_MODE, w);
      #1 chk(mdec, mexp(w));
    end
    wr(`ADDR_PIN_DIR, 16'hffff); rd(`ADDR_PIN_DIR); chk(d, 16'h00ff);
    for (int k = 0; k < 3; k++) begin
      w = 16'($urandom);
      wr(`ADDR_PIN_OUT, w); wr(`ADDR_PIN_DIR, {8'h0, w[15:8]}); want <= 8'($urandom);
      repeat (3) @(posedge clk);
      #1 chk(port_oe, w[15:8]);
      chk(pin_level, (w[7:0] & w[15:8]) | (~w[15:8] & want));
    end
    $display("mode and output test done");
    wr(`ADDR_PIN_DIR, 16'h0); wr(`ADDR_PIN_SENSE, 16'h0);
    for (int k = 0; k < 8; k++) begin
      @(posedge clk) want <= 8'($urandom);
      repeat (6) @(posedge clk);
      rd(`ADDR_PIN_IN); chk(d, {8'h0, want});
      for (int i = 0; i < 8; i++) begin
        @(posedge clk) {cond_sel, cond_inv} <= {5'(16 + i), i[0]};
        #1 chk(cond_true, want[i] ^ i[0]);
      end
    end
    @(posedge clk) want <= 8'hff;
    wr(`ADDR_PIN_SENSE, 16'hffff);
    repeat (6) @(posedge clk);
    for (int i = 0; i < 8; i++) ctest(5'(16 + i));
    rd(`ADDR_PIN_IN); chk(d, 16'h0);
    @(posedge clk) want <= 8'h00;
    repeat (6) @(posedge clk) want <= 8'hff;
    repeat (6) @(posedge clk);
    rd(`ADDR_PIN_IN); chk(d, 16'h00ff);
    ctest(5'h13); rd(`ADDR_PIN_IN); chk(d, 16'h00f7);
    $display("port input test done");
    for (int k = 0; k < 3; k++) begin
      w = 16'($urandom);
      wr(`ADDR_FLAGS, w); rd(`ADDR_FLAGS); chk(d, w & 16'hdfff);
      chk(loop_level_pointer, w[15:14]);
      for (int j = 0; j < 32; j++) begin
        @(posedge clk) {cond_sel, cond_inv} <= {5'(j >> 1), j[0]};
        #1 chk(cond_true, ce(w, 5'(j >> 1), j[0]));
      end
    end
    wr(`ADDR_FLAGS, 16'h0); alu(40'h0040000000, 1'b0); alu(40'h0, 1'b1); alu(40'h0, 1'b0);
    rd(`ADDR_FLAGS); chk({d[7], d[6], d[4]}, 3'b101);
    ctest(`COND_MN); ctest(`COND_STICKY_OVERFLOW_FLAG); rd(`ADDR_FLAGS); chk({d[7], d[4]}, 2'b00);
    for (int k = 0; k < 8; k++) alu({8'($urandom), 32'($urandom)}, 1'($urandom));
    wr(`ADDR_FLAGS, 16'h0);
    @(posedge clk) loop_inc <= 1'b1;
    repeat (2) @(posedge clk);
    loop_inc <= 1'b0;
    loop_dec <= 1'b1;
    @(posedge clk) loop_dec <= 1'b0;
    #1 chk(loop_level_pointer, 2'h1);
    $display("flag test done");
    @(posedge clk) irq_trigger <= 1'b1;
    @(posedge clk) irq_trigger <= 1'b0;
    rd(`ADDR_MODE); chk(d[14], 1'b1);
    @(posedge clk) irq_ack <= 1'b1;
    @(posedge clk) irq_ack <= 1'b0;
    rd(`ADDR_MODE); chk(d[14], 1'b0);
    wr(`ADDR_MODE, 16'h4000); #1 chk(irq_pending, 1'b1);
    $display("interrupt flag test done");
    give_verdict;
  end
  // the tests need well under 3000 cycles; this cuts a hang short
  initial begin
    #100us;
    fails++;
    give_verdict;
  end
endmodule
